// [logic/ccdt_readout.sv]
// ccdt_readout: timing generator that exposes and reads a full frame ccd
// assumes the sensor phases are level shifted off chip; one clock domain
// Summary of operation
// - vertical phases held low during exposure
// - line transfer on v2 fall, h1 high
// - h1 and h2 toggle complementary per pixel
// - reset gate pulses after each sample
`timescale 1ns/1ns
`default_nettype none
module ccdt_readout
  import ccdt_pkg::*;
#(
  parameter int COLS  = TOTAL_COLS,
  parameter int LINES = TOTAL_LINES
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // frame control
  input  wire logic        i_start,
  input  wire logic        i_expose_end,
  output logic             o_busy,
  output logic             o_frame_done,
  // sensor phases
  output logic             o_vertical_phase_one,
  output logic             o_vertical_phase_two,
  output logic             o_horizontal_phase_one,
  output logic             o_horizontal_phase_two,
  output logic             o_last_horizontal_phase,
  output logic             o_reset_gate_clock,
  // sampling front end
  output logic             o_sample,
  output logic [12:0]      o_col,
  output logic [11:0]      o_line,
  output logic [2:0]       o_region,
  output logic             o_dark_ref,
  output logic [1:0]       o_color
);
  ccdt_state_t state;      // sequencer state
  logic [4:0]  tcnt;       // phase timer
  logic [12:0] col;        // pixel counter
  logic [11:0] line;       // line counter
  logic        hph;        // 0 first half of pixel, 1 second half
  logic        exp_sync1;  // exposure end synchroniser stages
  logic        exp_sync2;
  logic        start_s1;   // start synchroniser stages
  logic        start_s2;
  ccdt_pos_if  pos ();

  // pin inputs cross two flops before use
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      exp_sync1 <= 1'b0;
      exp_sync2 <= 1'b0;
      start_s1  <= 1'b0;
      start_s2  <= 1'b0;
    end else begin
      exp_sync1 <= i_expose_end;
      exp_sync2 <= exp_sync1;
      start_s1  <= i_start;
      start_s2  <= start_s1;
    end
  end

  // sequencer: expose, vertical transfer, horizontal shift
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state <= CCDT_IDLE;
      tcnt  <= 5'h0;
      col   <= 13'h0;
      line  <= 12'h0;
      hph   <= 1'b0;
    end else begin
      unique case (state)
        CCDT_IDLE: begin
          if (start_s2) begin
            state <= CCDT_EXPOSE;
            line  <= 12'h0;
          end
        end
        CCDT_EXPOSE: begin
          if (exp_sync2) begin
            state <= CCDT_V1;              // vertical transfer starts: v1 goes high
            tcnt  <= 5'h0;
          end
        end
        CCDT_V1: begin
          tcnt <= tcnt + 5'h1;
          if (int'(tcnt) == VPHASE_CYC - 1) begin
            state <= CCDT_V2;
            tcnt  <= 5'h0;
          end
        end
        CCDT_V2: begin
          tcnt <= tcnt + 5'h1;
          if (int'(tcnt) == VPHASE_CYC - 1) begin
            state <= CCDT_V2FALL;
            tcnt  <= 5'h0;
          end
        end
        CCDT_V2FALL: begin
          // v2 now low: settle before shifting starts
          tcnt <= tcnt + 5'h1;
          if (int'(tcnt) == VPHASE_CYC - 1) begin
            state <= CCDT_HSHIFT;
            tcnt  <= 5'h0;
            col   <= 13'h0;
            hph   <= 1'b0;
          end
        end
        CCDT_HSHIFT: begin
          tcnt <= tcnt + 5'h1;
          if (int'(tcnt) == HALF_PIX_CYC - 1) begin
            tcnt <= 5'h0;
            hph  <= ~hph;
            if (hph) begin
              // whole register shifted before next line
              if (int'(col) == COLS - 1) begin
                col <= 13'h0;
                if (int'(line) == LINES - 1) begin
                  state <= CCDT_IDLE;
                end else begin
                  line  <= line + 12'h1;
                  state <= CCDT_V1;
                end
              end else begin
                col <= col + 13'h1;
              end
            end
          end
        end
        default: state <= CCDT_IDLE;
      endcase
    end
  end

  // phase outputs registered
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_vertical_phase_one    <= 1'b0;
      o_vertical_phase_two    <= 1'b0;
      o_horizontal_phase_one  <= 1'b1;
      o_horizontal_phase_two  <= 1'b0;
      o_last_horizontal_phase <= 1'b1;
    end else begin
      o_vertical_phase_one <= (state == CCDT_V1);
      o_vertical_phase_two <= (state == CCDT_V2);
      if (state == CCDT_HSHIFT) begin
        // complementary h clocks, one pixel per full cycle
        o_horizontal_phase_one  <= ~hph;
        o_horizontal_phase_two  <= hph;
        // last phase falls with h1: packet onto sense node
        o_last_horizontal_phase <= ~hph;
      end else begin
        // h1 held high through vertical transfer
        o_horizontal_phase_one  <= 1'b1;
        o_horizontal_phase_two  <= 1'b0;
        o_last_horizontal_phase <= 1'b1;
      end
    end
  end

  // sample strobe then reset gate, both in the second half pixel
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_sample           <= 1'b0;
      o_reset_gate_clock <= 1'b0;
    end else begin
      o_sample <= (state == CCDT_HSHIFT) && hph &&
                  (int'(tcnt) == SAMPLE_CYC - 1);
      // reset after sample, before the next packet
      o_reset_gate_clock <= (state == CCDT_HSHIFT) && hph &&
                            (int'(tcnt) >= SAMPLE_CYC) &&
                            (int'(tcnt) < SAMPLE_CYC + RG_CYC);
    end
  end

  // pixel position and its classification
  assign pos.col  = col;
  assign pos.line = line;
  ccdt_classify u_class (
    .p (pos.src)
  );

  // position and class registered with the sample
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_col      <= 13'h0;
      o_line     <= 12'h0;
      o_region   <= REG_DUMMY;
      o_dark_ref <= 1'b0;
      o_color    <= 2'h0;
    end else begin
      o_col      <= col;
      o_line     <= line;
      o_region   <= pos.region;
      o_dark_ref <= pos.dark_ref;
      o_color    <= pos.color;
    end
  end

  // status
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_frame_done <= 1'b0;
    end else begin
      o_frame_done <= (state == CCDT_HSHIFT) && hph && (int'(col) == COLS - 1)
                      && (int'(line) == LINES - 1)
                      && (int'(tcnt) == HALF_PIX_CYC - 1);
    end
  end
  assign o_busy = (state != CCDT_IDLE);
endmodule : ccdt_readout
`default_nettype wire

// [logic/ccdt_pkg.sv]
// ccdt_pkg: frame geometry and phase timing for the ccd readout controller
// assumes the 125 MHz system clock; timing counts are in clock cycles
package ccdt_pkg;
  // full readout array
  localparam int TOTAL_COLS      = 4641;
  localparam int TOTAL_LINES     = 3695;
  // effective region, buffer pixels included
  localparam int EFF_COLS        = 4540;
  localparam int EFF_LINES       = 3640;
  // active image region
  localparam int ACT_COLS        = 4500;
  localparam int ACT_LINES       = 3600;
  // leading extra shift phases in the horizontal register
  localparam int DUMMY_COLS      = 20;
  // leading shielded pixels of each line
  localparam int DARK_COLS       = 36;
  // shielded lines at frame start and end
  localparam int DARK_LINES_HEAD = 30;
  localparam int DARK_LINES_TAIL = 23;
  // unshielded buffer pixels around the active area
  localparam int BUF_PIX         = 20;
  // blue-filtered pixels at the start of the leading buffer columns
  localparam int BLUE_LEAD       = 4;
  // pixel region codes
  localparam logic [2:0] REG_DUMMY  = 3'h0;
  localparam logic [2:0] REG_DARK   = 3'h1;
  localparam logic [2:0] REG_BUFFER = 3'h2;
  localparam logic [2:0] REG_ACTIVE = 3'h3;
  localparam logic [2:0] REG_TRAIL  = 3'h4;
  // phase timing in clock cycles (plain defaults, no figure printed)
  localparam int HALF_PIX_CYC    = 3;
  localparam int VPHASE_CYC      = 16;
  localparam int RG_CYC          = 1;
  // sample strobe position within a pixel
  localparam int SAMPLE_CYC      = 2;
  // controller states
  typedef enum logic [2:0] {
    CCDT_IDLE, CCDT_EXPOSE, CCDT_V1, CCDT_V2, CCDT_V2FALL, CCDT_HSHIFT
  } ccdt_state_t;
endpackage : ccdt_pkg

// [logic/ccdt_pos_if.sv]
// ccdt_pos_if: pixel position and region classification carrier
// assumes one clock domain shared by producer and consumer
`timescale 1ns/1ns
`default_nettype none
interface ccdt_pos_if;
  logic [12:0] col;      // pixel column within the line
  logic [11:0] line;     // line within the frame
  logic [2:0]  region;   // region code of the pixel
  logic        dark_ref; // usable as dark reference
  logic [1:0]  color;    // filter: 0 r, 1 gr, 2 gb, 3 b
  modport src (output region, dark_ref, color, input col, line);
  modport dst (input region, dark_ref, color, output col, line);
endinterface : ccdt_pos_if
`default_nettype wire

// [logic/ccdt_classify.sv]
// ccdt_classify: maps pixel position to region, dark flag and filter
// assumes col and line counted from the first shifted pixel and line
`timescale 1ns/1ns
`default_nettype none
module ccdt_classify
  import ccdt_pkg::*;
(
  // position in, classification out
  ccdt_pos_if.src p
);
  localparam int BUF_START = DUMMY_COLS + DARK_COLS;
  // first active column and first active line
  localparam int ACT_COL0  = BUF_START + BUF_PIX;
  localparam int ACT_ROW0  = DARK_LINES_HEAD + BUF_PIX;
  // region per column and line
  always_comb begin
    p.dark_ref = 1'b0;
    if (int'(p.col) < DUMMY_COLS) begin
      p.region = REG_DUMMY;
    end else if (int'(p.col) < BUF_START) begin
      p.region   = REG_DARK;
      p.dark_ref = 1'b1;
    end else if (int'(p.line) < DARK_LINES_HEAD ||
                 int'(p.line) >= TOTAL_LINES - DARK_LINES_TAIL) begin
      p.region   = REG_DARK;
      p.dark_ref = 1'b1;
    end else if (int'(p.col) >= BUF_START + EFF_COLS ||
                 int'(p.line) >= DARK_LINES_HEAD + EFF_LINES) begin
      // test columns and rows beyond the effective region
      p.region = REG_TRAIL;
    end else if (int'(p.col) < ACT_COL0 ||
                 int'(p.col) >= ACT_COL0 + ACT_COLS ||
                 int'(p.line) < ACT_ROW0 ||
                 int'(p.line) >= ACT_ROW0 + ACT_LINES) begin
      // buffer ring between active area and dark border
      p.region = REG_BUFFER;
    end else begin
      p.region = REG_ACTIVE;
    end
  end
  // filter colour: blue lead then bayer r, gr, gb, b
  always_comb begin
    if (int'(p.col) >= BUF_START && int'(p.col) < BUF_START + BLUE_LEAD) begin
      p.color = 2'h3;
    end else begin
      p.color = {p.line[0], p.col[0] ^ 1'b0};
    end
  end
endmodule : ccdt_classify
`default_nettype wire

// [tb/ccdt_readout_chk.sv]
// ccdt_readout_chk: phase timing checks on the readout controller
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module ccdt_readout_chk
  import ccdt_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // watched outputs
  input wire logic o_busy,
  input wire logic o_vertical_phase_one,
  input wire logic o_vertical_phase_two,
  input wire logic o_horizontal_phase_one,
  input wire logic o_horizontal_phase_two,
  input wire logic o_last_horizontal_phase,
  input wire logic o_reset_gate_clock,
  input wire logic o_sample
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  AST_V2_FALL_H1: assert property (
    $fell(o_vertical_phase_two) |-> o_horizontal_phase_one)
    else $error("line moved with h1 low");
  AST_H_COMPL: assert property (
    o_horizontal_phase_two |-> !o_horizontal_phase_one)
    else $error("h1 and h2 high together");
  AST_H2_HALF: assert property (
    $rose(o_horizontal_phase_two) |->
      o_horizontal_phase_two[*3] ##1 !o_horizontal_phase_two)
    else $error("h2 half pixel length wrong");
  AST_SAMPLE_POS: assert property (
    $rose(o_horizontal_phase_two) |->
      !o_sample ##1 o_sample ##1 (o_reset_gate_clock && !o_sample))
    else $error("sample or reset gate misplaced");
  AST_RG_PULSE: assert property (
    o_reset_gate_clock |-> $past(o_sample) ##1 !o_reset_gate_clock)
    else $error("reset gate not a pulse after sample");
  AST_LAST_FOLLOW: assert property (
    $rose(o_horizontal_phase_two) |-> ##[0:1] !o_last_horizontal_phase)
    else $error("last phase did not fall with h1");
  AST_VSEQ: assert property (
    (o_vertical_phase_one || o_vertical_phase_two) |->
      !o_horizontal_phase_two && o_horizontal_phase_one)
    else $error("shifting during line transfer");
  AST_IDLE_LOW: assert property (
    !o_busy |-> !o_vertical_phase_one && !o_vertical_phase_two)
    else $error("vertical phase high while idle");
endmodule : ccdt_readout_chk
bind ccdt_readout ccdt_readout_chk ccdt_readout_chk_inst (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .o_busy(o_busy),
  .o_vertical_phase_one(o_vertical_phase_one),
  .o_vertical_phase_two(o_vertical_phase_two),
  .o_horizontal_phase_one(o_horizontal_phase_one),
  .o_horizontal_phase_two(o_horizontal_phase_two),
  .o_last_horizontal_phase(o_last_horizontal_phase),
  .o_reset_gate_clock(o_reset_gate_clock), .o_sample(o_sample));
`default_nettype wire

// [tb/ccdt_sensor_model.sv]
// ccdt_sensor_model: behavioural full frame sensor, tallies packets
// assumes phases arrive straight from the controller outputs
`timescale 1ns/1ns
`default_nettype none
module ccdt_sensor_model
  import ccdt_pkg::*;
(
  // sensor phase pins
  input  wire logic v2,
  input  wire logic h1,
  input  wire logic last,
  // tallies seen by the bench
  output var  int   n_lines,
  output var  int   n_pkts,
  output var  int   n_dark
);
  int   pix = 0;   // packet index within line, spans array width
  logic pv2 = 0;   // previous v2 level
  logic pl  = 0;   // previous last phase level
  initial begin
    n_lines = 0;
    n_pkts  = 0;
    n_dark  = 0;
  end
  // new line enters the register on v2 fall with h1 high
  always @(v2) begin
    if (pv2 === 1'b1 && v2 === 1'b0 && h1 === 1'b1) begin
      n_lines++;
      pix = 0;
    end
    pv2 = v2;
  end
  // each fall of the last phase dumps one packet on the sense node
  always @(last) begin
    if (pl === 1'b1 && last === 1'b0) begin
      // shielded columns follow the leading dummy phases
      if (pix >= DUMMY_COLS && pix < DUMMY_COLS + DARK_COLS)
        n_dark++;
      n_pkts++;
      pix++;
    end
    pl = last;
  end
endmodule : ccdt_sensor_model
`default_nettype wire

// [tb/tb_ccdt_readout.sv]
// tb_ccdt_readout: self-checking bench for the readout controller
// assumes a 125 MHz clock and a frame shortened to 60 by 4
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
  $display("wrong value at %0t got %h exp %h", $time, a, e); end end
module tb_ccdt_readout import ccdt_pkg::*;;
  localparam int COLS = 60, LINES = 4, LIM = 5000;
  localparam int LEAD0 = DUMMY_COLS + DARK_COLS;
  logic i_clk = 0, i_rst_b = 0, i_start = 0, i_expose_end = 0;
  logic busy, done, v1, v2, h1, h2, lst, smp, dref, expo = 0;
  logic [12:0] col;
  logic [11:0] lin;
  logic [2:0] rgn;
  logic [1:0] clr;
  int failures = 0, n_checks = 0, seed = 62, p = 0, nl = 0, frames = 0;
  int m_lines, m_pkts, m_dark;
  always #4 i_clk = ~i_clk;
  ccdt_readout #(.COLS(COLS), .LINES(LINES)) ccdt_readout_inst (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_start(i_start),
    .i_expose_end(i_expose_end), .o_busy(busy), .o_frame_done(done),
    .o_vertical_phase_one(v1), .o_vertical_phase_two(v2),
    .o_horizontal_phase_one(h1), .o_horizontal_phase_two(h2),
    .o_last_horizontal_phase(lst), .o_reset_gate_clock(), .o_sample(smp),
    .o_col(col), .o_line(lin), .o_region(rgn), .o_dark_ref(dref),
    .o_color(clr));
  ccdt_sensor_model ccdt_sensor_model_inst (.v2(v2), .h1(h1), .last(lst),
    .n_lines(m_lines), .n_pkts(m_pkts), .n_dark(m_dark));
  // rule model of the pixel class: {region, dark reference flag}
  function automatic logic [3:0] exp_cls(input int c, input int l);
    if (c < DUMMY_COLS) return {REG_DUMMY, 1'b0};
    if (c < LEAD0 || l < DARK_LINES_HEAD ||
        l >= TOTAL_LINES - DARK_LINES_TAIL)
      return {REG_DARK, 1'b1};
    if (c >= LEAD0 + EFF_COLS || l >= DARK_LINES_HEAD + EFF_LINES)
      return {REG_TRAIL, 1'b0};
    if (c < LEAD0 + BUF_PIX || c >= LEAD0 + BUF_PIX + ACT_COLS ||
        l < DARK_LINES_HEAD + BUF_PIX ||
        l >= DARK_LINES_HEAD + BUF_PIX + ACT_LINES)
      return {REG_BUFFER, 1'b0};
    return {REG_ACTIVE, 1'b0};
  endfunction : exp_cls
  // reference model: pixel and line counts, column classes
  always @(posedge i_clk) if (i_rst_b) begin
    if (expo) `CHK({v1, v2}, 2'b00)
    if ($fell(v2)) begin
      if (nl > 0) `CHK(p, COLS)
      nl++;
      p = 0;
    end
    if (smp) begin
      `CHK(col, 13'(p))
      `CHK({rgn, dref}, exp_cls(p, nl - 1))
      `CHK(lin, 12'(nl - 1))
      if (p >= LEAD0 && p < LEAD0 + BLUE_LEAD) `CHK(clr, 2'h3)
      p++;
    end
    if (done) begin
      `CHK(nl, LINES)
      `CHK(p, COLS)
      nl = 0;
    end
  end
  task finish_test;
    if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  // bounded wait: 0 busy, 1 v1, 2 frame done
  task automatic wait_for(input int s);
    int k = 0;
    while ((s == 0 ? busy : s == 1 ? v1 : done) !== 1'b1 && k < LIM) begin
      @(negedge i_clk);
      k++;
    end
    if (k >= LIM) begin failures++; finish_test(); end
  endtask : wait_for
  // one frame: start, random exposure, readout with refused requests
  task automatic frame;
    int k = 0;
    i_start = 1;
    repeat (3) @(negedge i_clk);
    i_start = 0;
    wait_for(0);
    expo = 1;
    repeat (8 + {$random(seed)} % 16) @(negedge i_clk);
    expo = 0;
    i_expose_end = 1;
    repeat (3) @(negedge i_clk);
    i_expose_end = 0;
    wait_for(1);
    while (v1 === 1'b1 && k < 40) begin @(negedge i_clk); k++; end
    `CHK(k, VPHASE_CYC)
    i_start = 1;
    i_expose_end = 1;
    repeat (4) @(negedge i_clk);
    i_start = 0;
    i_expose_end = 0;
    wait_for(2);
    frames++;
    repeat (10) @(negedge i_clk);
    `CHK(busy, 1'b0)
    `CHK(m_lines, frames * LINES)
    `CHK(m_pkts, frames * LINES * COLS)
    `CHK(m_dark, frames * LINES * DARK_COLS)
  endtask : frame
  initial begin
    repeat (5) @(negedge i_clk);
    i_rst_b = 1;
    repeat (2) @(negedge i_clk);
    repeat (2) frame();
    finish_test();
  end
endmodule : tb_ccdt_readout
`default_nettype wire
